// ==== hw/swc_pkg.sv ====
// package: constants, register map and carriers for sleep and wake-up control
package swc_pkg;
	localparam int SWC_DW = 8;
	localparam int SWC_AW = 4;
	// register indices (chosen map)
	localparam logic [3:0] SWC_A_IOC   = 4'h0;
	localparam logic [3:0] SWC_A_ICTL  = 4'h1;
	localparam logic [3:0] SWC_A_PERIPH_ENABLES_ONE  = 4'h2;
	localparam logic [3:0] SWC_A_PERIPH_ENABLES_TWO  = 4'h3;
	localparam logic [3:0] SWC_A_PERIPH_FLAGS_ONE  = 4'h4;
	localparam logic [3:0] SWC_A_PERIPH_FLAGS_TWO  = 4'h5;
	localparam logic [3:0] SWC_A_STAT  = 4'h6;
	localparam logic [3:0] SWC_A_CFG   = 4'h7;
	// irq_control fields
	localparam int SWC_B_GIE  = 7;
	localparam int SWC_B_PEIE = 6;
	localparam int SWC_B_T0IE = 5;
	localparam int SWC_B_INTE = 4;
	localparam int SWC_B_RBIE = 3;
	localparam int SWC_B_T0IF = 2;
	localparam int SWC_B_EXT_IRQ_FLAG = 1;
	localparam int SWC_B_RBIF = 0;
	// periph_flags_one (P1) and flags two (P2) positions of sources able to wake
	localparam int SWC_P1_ADC  = 6;
	localparam int SWC_P1_RX   = 5;
	localparam int SWC_P1_SSP  = 3;
	localparam int SWC_P1_CAPA = 2;
	localparam int SWC_P1_LOW_POWER_TIMER = 0;
	localparam int SWC_P2_CAPB = 0;
	// status fields
	localparam int SWC_S_TO    = 4;
	localparam int SWC_S_PD    = 3;
	localparam int SWC_S_SLEEP = 0;
	localparam int SWC_C_XTAL  = 0;
	localparam logic [7:0] SWC_PERIPH_ENABLES_TWO_MASK = 8'h01;
	localparam logic [7:0] SWC_ZERO8 = 8'h00;
	localparam logic [7:0] SWC_INIT8 = 8'h00;
	localparam logic [7:0] SWC_VECTOR = 8'h04;
	// timing: oscillator periods
	localparam int SWC_OST_TOSC   = 1024;
	localparam int SWC_Q_PER_INST = 4;
	localparam logic [1:0] SWC_Q_LAST = 2'(SWC_Q_PER_INST - 1);

	typedef enum logic [1:0] {SWC_RUN, SWC_SLEEP, SWC_OST, SWC_DUMMY} swc_state_e;

	// which wake-capable source is asleep-qualified this cycle
	typedef struct packed {
		logic low_power_timer_async;
		logic rx_sync_slave;
		logic adc_rc_clk;
		logic ssp_slave;
	} swc_qual_s;

	typedef struct packed {
		logic [SWC_AW-1:0] addr;
		logic [SWC_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} swc_bus_s;
endpackage

// ==== hw/swc_top.sv ====
// sleep entry and wake-up controller with its interrupt enable/flag registers
//
// Overview of operation
// R1: sleep with watchdog: clear count, flags, oscillator off
// R2: asleep: slow timer runs, ports hold drive
// R3: watchdog reset never drives external reset pin
// R4: wake on pin reset, watchdog, enabled interrupt
// R5: power-down flag set at power-up, cleared on sleep
// R6: only listed peripheral interrupts can wake
// R7: clock-dependent peripherals raise nothing while asleep
// R8: next instruction prefetched during sleep instruction
// R9: individual enable needed; global enable ignored
// R10: global enable set: run prefetched, then vector
// R11: watchdog cleared on every wake-up
// R12: pending enabled interrupt turns sleep into no-op
// R13: interrupt during sleep instruction: complete, wake
// R14: crystal modes wait 1024 oscillator periods
// R15: software adds no-op, clears watchdog first
// R16: software reads power-down flag to detect sleep
// R17: instruction cycle is four oscillator periods
// R18: one sleep flip-flop gates core clock enable
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module swc_top
	import swc_pkg::*;
#(
	parameter int OST_CYCLES = swc_pkg::SWC_OST_TOSC
) (
	input  wire logic                   sys_clk,
	input  wire logic                   nrst,
	input  wire logic                   por_event,
	input  wire swc_pkg::swc_bus_s      bus,
	output logic [swc_pkg::SWC_DW-1:0]  rdata,
	input  wire logic                   sleep_op,
	input  wire logic                   watchdog_clear_op,
	input  wire logic                   wdt_enable,
	input  wire logic                   wdt_timeout,
	input  wire logic [7:0]             port_in_pins,
	input  wire logic                   external_interrupt_pin,
	input  wire logic [7:0]             periph_raise_one,
	input  wire logic                   capture_unit_b_raise,
	input  wire swc_pkg::swc_qual_s     qual,
	input  wire logic [7:0]             port_out_core,
	input  wire logic [7:0]             port_oe_core,
	output logic [7:0]                  port_out,
	output logic [7:0]                  port_oe,
	output logic                        core_clk_en,
	output logic                        osc_drv_en,
	output logic                        lp_timer_osc_en,
	output logic                        wdt_clear,
	output logic                        wdt_reset_int,
	output logic                        ext_reset_drive_n,
	output logic                        vector_req,
	output logic [7:0]                  vector_addr,
	output logic                        prefetch_next,
	output logic [1:0]                  q_phase
);
	import swc_pkg::*;

	localparam int OSTW = $clog2(OST_CYCLES + 1);

	logic [7:0] pin_change_enables_r, irq_control_r, periph_enables_one_r;
	logic [7:0] periph_enables_two_r, periph_flags_one_r, periph_flags_two_r;
	logic       power_down_flag_r, timeout_flag_r, xtal_mode_r;
	logic       asleep_r;
	swc_state_e state_r;
	logic [OSTW-1:0] ost_cnt_r;
	logic [7:0] pins_prev_r;
	logic       int_pin_prev_r;

	logic wr, rd;
	assign wr = bus.wr;
	assign rd = bus.rd;

	// flags raised by hardware; only wake-capable ones while asleep
	logic [7:0] p1_wake_mask;
	logic [7:0] p1_set;
	logic       rb_change, int_edge;
	always_comb begin
		p1_wake_mask = SWC_ZERO8;
		p1_wake_mask[SWC_P1_LOW_POWER_TIMER] = qual.low_power_timer_async;    // [R6]
		p1_wake_mask[SWC_P1_RX]   = qual.rx_sync_slave; // [R6]
		p1_wake_mask[SWC_P1_ADC]  = qual.adc_rc_clk;    // [R6]
		p1_wake_mask[SWC_P1_SSP]  = qual.ssp_slave;     // [R6]
		p1_wake_mask[SWC_P1_CAPA] = 1'b1;               // [R6]
		// on-chip clocks are stopped, so other sources are blocked asleep
		p1_set = asleep_r ? (periph_raise_one & p1_wake_mask) : periph_raise_one; // [R7]
	end
	assign rb_change = |((port_in_pins ^ pins_prev_r) & pin_change_enables_r);
	assign int_edge  = external_interrupt_pin & ~int_pin_prev_r;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pins_prev_r    <= SWC_ZERO8;
			int_pin_prev_r <= 1'b0;
		end else begin
			pins_prev_r    <= port_in_pins;
			int_pin_prev_r <= external_interrupt_pin;
		end
	end

	// pending wake: individual enable and flag, global enable ignored
	logic wake_irq;
	assign wake_irq = (irq_control_r[SWC_B_INTE] & irq_control_r[SWC_B_EXT_IRQ_FLAG])
		| (irq_control_r[SWC_B_RBIE] & irq_control_r[SWC_B_RBIF])
		| (|(periph_enables_one_r & periph_flags_one_r))
		| (|(periph_enables_two_r & periph_flags_two_r & SWC_PERIPH_ENABLES_TWO_MASK)); // [R9]

	logic do_sleep, enter_sleep, wake_now;
	assign do_sleep    = sleep_op && state_r == SWC_RUN;
	assign enter_sleep = do_sleep && !wake_irq;                       // [R12]
	assign wake_now    = asleep_r && (wake_irq || wdt_timeout);       // [R4]

	// registers; hardware set wins over software write
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin_change_enables_r <= SWC_INIT8;
			periph_enables_one_r <= SWC_INIT8;
			periph_enables_two_r <= SWC_INIT8;
			xtal_mode_r          <= 1'b0;
		end else if (wr) begin
			unique case (bus.addr)
				SWC_A_IOC:  pin_change_enables_r <= bus.wdata;
				SWC_A_PERIPH_ENABLES_ONE: periph_enables_one_r <= bus.wdata;
				SWC_A_PERIPH_ENABLES_TWO: periph_enables_two_r <= bus.wdata & SWC_PERIPH_ENABLES_TWO_MASK;
				SWC_A_CFG:  xtal_mode_r          <= bus.wdata[SWC_C_XTAL];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_control_r      <= SWC_INIT8;
			periph_flags_one_r <= SWC_INIT8;
			periph_flags_two_r <= SWC_INIT8;
		end else begin
			irq_control_r <= ((wr && bus.addr == SWC_A_ICTL) ? bus.wdata : irq_control_r)
				| {6'h00, int_edge, rb_change};
			periph_flags_one_r <= ((wr && bus.addr == SWC_A_PERIPH_FLAGS_ONE) ? bus.wdata
				: periph_flags_one_r) | p1_set;
			periph_flags_two_r <= (((wr && bus.addr == SWC_A_PERIPH_FLAGS_TWO) ? bus.wdata
				: periph_flags_two_r) | {7'h00, capture_unit_b_raise}) & SWC_PERIPH_ENABLES_TWO_MASK;
		end
	end

	// status flags; power-up sets power-down flag
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			power_down_flag_r <= 1'b1;
			timeout_flag_r    <= 1'b1;
		end else if (por_event) begin
			power_down_flag_r <= 1'b1;                                 // [R5]
			timeout_flag_r    <= 1'b1;
		end else if (enter_sleep) begin
			power_down_flag_r <= 1'b0;                                 // [R1] [R5] [R13]
			timeout_flag_r    <= 1'b1;                                 // [R1] [R13]
		end else if (asleep_r && wdt_timeout) begin
			timeout_flag_r    <= 1'b0;                                 // [R4]
		end else if (watchdog_clear_op) begin
			power_down_flag_r <= 1'b1;
			timeout_flag_r    <= 1'b1;
		end
	end

	// sleep flip-flop and post-wake sequencing
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r   <= SWC_RUN;
			asleep_r  <= 1'b0;
			ost_cnt_r <= '0;
		end else begin
			unique case (state_r)
				SWC_RUN: if (enter_sleep) begin
					state_r  <= SWC_SLEEP;
					asleep_r <= 1'b1;                                    // [R18]
				end
				SWC_SLEEP: if (wake_now) begin
					asleep_r  <= 1'b0;                                   // [R18]
					ost_cnt_r <= OSTW'(OST_CYCLES - 1);
					state_r   <= xtal_mode_r ? SWC_OST : SWC_DUMMY;      // [R14]
				end
				SWC_OST: begin
					ost_cnt_r <= ost_cnt_r - OSTW'(1);
					if (ost_cnt_r == '0) state_r <= SWC_DUMMY;           // [R14]
				end
				SWC_DUMMY: state_r <= SWC_RUN;
			endcase
		end
	end

	// instruction phase counter, frozen while the core is held
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) q_phase <= 2'b00;
		else if (state_r == SWC_RUN || state_r == SWC_DUMMY)
			q_phase <= (q_phase == SWC_Q_LAST) ? 2'b00 : q_phase + 2'b01; // [R17]
	end

	// outputs, all registered
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			core_clk_en       <= 1'b1;
			osc_drv_en        <= 1'b1;
			lp_timer_osc_en   <= 1'b1;
			wdt_clear         <= 1'b0;
			wdt_reset_int     <= 1'b0;
			ext_reset_drive_n <= 1'b1;
			vector_req        <= 1'b0;
			vector_addr       <= SWC_ZERO8;
			prefetch_next     <= 1'b0;
			port_out          <= SWC_ZERO8;
			port_oe           <= SWC_ZERO8;
			rdata             <= SWC_ZERO8;
		end else begin
			// a crystal wake keeps the core held straight into the start-up wait
			core_clk_en <= !(enter_sleep || (asleep_r && !(wake_now && !xtal_mode_r))
				|| (state_r == SWC_OST && ost_cnt_r != '0));           // [R18] [R14]
			osc_drv_en  <= !(enter_sleep || (asleep_r && !wake_now));   // [R1]
			lp_timer_osc_en <= 1'b1;                                    // [R2]
			wdt_clear   <= (enter_sleep && wdt_enable) || wake_now;     // [R1] [R11]
			// watchdog reset only while awake; asleep it wakes instead
			wdt_reset_int <= wdt_timeout && !asleep_r && state_r == SWC_RUN;
			ext_reset_drive_n <= 1'b1;                                  // [R3]
			vector_req  <= (state_r == SWC_DUMMY) && irq_control_r[SWC_B_GIE]; // [R10]
			vector_addr <= SWC_VECTOR;                                  // [R10]
			prefetch_next <= do_sleep;                                  // [R8]
			if (!(asleep_r || enter_sleep)) begin
				port_out <= port_out_core;
				port_oe  <= port_oe_core;
			end                                                          // [R2]
			rdata <= SWC_ZERO8;
			if (rd) begin
				unique case (bus.addr)
					SWC_A_IOC:  rdata <= pin_change_enables_r;
					SWC_A_ICTL: rdata <= irq_control_r;
					SWC_A_PERIPH_ENABLES_ONE: rdata <= periph_enables_one_r;
					SWC_A_PERIPH_ENABLES_TWO: rdata <= periph_enables_two_r;
					SWC_A_PERIPH_FLAGS_ONE: rdata <= periph_flags_one_r;
					SWC_A_PERIPH_FLAGS_TWO: rdata <= periph_flags_two_r;
					SWC_A_STAT: rdata <= {3'b000, timeout_flag_r, power_down_flag_r,
						2'b00, asleep_r};                                   // [R16]
					SWC_A_CFG:  rdata <= {7'h00, xtal_mode_r};
					default:    rdata <= SWC_ZERO8;
				endcase
			end
		end
	end

	sequence s_sleep_taken;
		do_sleep && !wake_irq;
	endsequence
	sequence s_core_stopped;
		!core_clk_en && !osc_drv_en;
	endsequence

	a_sleep_entry: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
		(s_sleep_taken and !por_event)
		|=> (s_core_stopped and (!power_down_flag_r && timeout_flag_r)))
		else $error("sleep entry did not stop clocks or update flags");
	a_noop_sleep: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
		do_sleep && wake_irq |=> !asleep_r && !wdt_clear)
		else $error("pending interrupt did not make sleep a no-op");
	a_wake_clear: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
		wake_now |=> wdt_clear && !asleep_r)
		else $error("wake-up did not clear watchdog");
	a_pin_never: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
		wdt_timeout |=> ext_reset_drive_n)
		else $error("watchdog drove reset pin");
	a_ports_held: assert property (@(posedge sys_clk) disable iff (!nrst) // [R2]
		asleep_r && $past(asleep_r) |-> $stable(port_out) && $stable(port_oe) && lp_timer_osc_en)
		else $error("port state changed in sleep");
	a_wake_gate: assert property (@(posedge sys_clk) disable iff (!nrst) // [R9]
		asleep_r && !wake_irq && !wdt_timeout |=> asleep_r)
		else $error("woke without enabled source");
	a_vector_gie: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
		state_r == SWC_DUMMY |=> vector_req == $past(irq_control_r[SWC_B_GIE]))
		else $error("vector request mismatch after wake");
	a_ost_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // [R14]
		state_r == SWC_SLEEP && wake_now && xtal_mode_r
		|=> state_r == SWC_OST && !core_clk_en ##1 !core_clk_en)
		else $error("start-up delay skipped in crystal mode");
	a_prefetch: assert property (@(posedge sys_clk) disable iff (!nrst) // [R8]
		do_sleep |=> prefetch_next)
		else $error("no prefetch during sleep instruction");
	a_pd_powerup: assert property (@(posedge sys_clk) disable iff (!nrst) // [R5]
		por_event |=> power_down_flag_r)
		else $error("power-down flag not set at power-up");
	a_sleep_block: assert property (@(posedge sys_clk) disable iff (!nrst) // [R7]
		asleep_r && !qual.low_power_timer_async && periph_raise_one[SWC_P1_LOW_POWER_TIMER]
		&& !periph_flags_one_r[SWC_P1_LOW_POWER_TIMER] && !(wr && bus.addr == SWC_A_PERIPH_FLAGS_ONE)
		|=> !periph_flags_one_r[SWC_P1_LOW_POWER_TIMER])
		else $error("clock-dependent source flagged in sleep");
	a_quarter: assert property (@(posedge sys_clk) disable iff (!nrst) // [R17]
		q_phase == SWC_Q_LAST && state_r == SWC_RUN |=> q_phase == 2'b00)
		else $error("instruction cycle not four phases");
endmodule
`default_nettype wire

// ==== tb/swc_core_model.sv ====
// core and watchdog model: issues sleep, watchdog-clear and time-out events
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
	input  wire logic sys_clk,
	input  wire logic core_clk_en,
	output logic      sleep_op,
	output logic      watchdog_clear_op,
	output logic      wdt_timeout
);
	initial begin
		sleep_op = 1'b0;
		watchdog_clear_op = 1'b0;
		wdt_timeout = 1'b0;
	end
	// a stopped core executes nothing, so wait for its clock enable first
	task automatic sleep(input logic clr);
		while (core_clk_en !== 1'b1) @(posedge sys_clk);
		if (clr) begin
			@(posedge sys_clk) watchdog_clear_op <= 1'b1;
			@(posedge sys_clk) watchdog_clear_op <= 1'b0;
		end
		@(posedge sys_clk) sleep_op <= 1'b1;
		@(posedge sys_clk) sleep_op <= 1'b0;
	endtask
	task automatic timeout();
		@(posedge sys_clk) wdt_timeout <= 1'b1;
		@(posedge sys_clk) wdt_timeout <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: register access, sleep entry, wake-up sources and timing
`timescale 1ns/1ps
`default_nettype none
module tb;
	import swc_pkg::*;
	localparam int OST = 8;
	logic sys_clk = 1'b0, nrst = 1'b0, por_event = 1'b0, wdt_enable = 1'b1, ext_pin = 1'b0;
	swc_bus_s   bus = '0;
	swc_qual_s  qual = '0;
	logic [7:0] rdata, raise = 8'h00, pins = 8'h00, pout_core = 8'h00, poe_core = 8'h00;
	logic [7:0] port_out, port_oe, vector_addr, pv, qp;
	logic       sleep_op, wcl, wto, core_clk_en, osc_drv_en, lp_en, wdt_clear, wdt_reset_int;
	logic       ext_n, vector_req, prefetch_next, rd_q = 1'b0, cap_b = 1'b0;
	logic [1:0] q_phase;
	int         failures = 0, checks = 0, seed = 59810, n;
	logic [7:0] q_exp[$];
	string      q_name[$];

	always #10 sys_clk = ~sys_clk;

	swc_top #(.OST_CYCLES(OST)) uut (.sys_clk(sys_clk), .nrst(nrst), .por_event(por_event),
		.bus(bus), .rdata(rdata), .sleep_op(sleep_op), .watchdog_clear_op(wcl),
		.wdt_enable(wdt_enable), .wdt_timeout(wto), .port_in_pins(pins),
		.external_interrupt_pin(ext_pin), .periph_raise_one(raise),
		.capture_unit_b_raise(cap_b), .qual(qual), .port_out_core(pout_core),
		.port_oe_core(poe_core), .port_out(port_out), .port_oe(port_oe),
		.core_clk_en(core_clk_en), .osc_drv_en(osc_drv_en), .lp_timer_osc_en(lp_en),
		.wdt_clear(wdt_clear), .wdt_reset_int(wdt_reset_int), .ext_reset_drive_n(ext_n),
		.vector_req(vector_req), .vector_addr(vector_addr), .prefetch_next(prefetch_next),
		.q_phase(q_phase));
	swc_core_model core (.sys_clk(sys_clk), .core_clk_en(core_clk_en), .sleep_op(sleep_op),
		.watchdog_clear_op(wcl), .wdt_timeout(wto));

	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// read results are compared from the queue, in issue order
	always @(posedge sys_clk) begin
		if (rd_q) check(q_name.pop_front(), rdata, q_exp.pop_front());
		rd_q <= bus.rd;
	end
	task automatic reg_wr(logic [3:0] a, logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic reg_rd(logic [3:0] a, logic [7:0] e, string nm);
		@(posedge sys_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		q_exp.push_back(e);
		q_name.push_back(nm);
		@(posedge sys_clk);
		bus.rd <= 1'b0;
	endtask
	task automatic wait_hi(int sel, output int cnt);
		cnt = 0;
		while (((sel == 0) ? core_clk_en : wdt_clear) !== 1'b1 && cnt < 50) begin
			@(posedge sys_clk);
			#1;
			cnt++;
		end
	endtask
	task automatic pin_pulse();
		@(posedge sys_clk) ext_pin <= 1'b1;
		repeat (2) @(posedge sys_clk);
		ext_pin <= 1'b0;
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#60000;
		failures++;
		complete_run();
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk) por_event <= 1'b1;
		@(posedge sys_clk) por_event <= 1'b0;
		reg_rd(SWC_A_STAT, 8'h18, "status after power-up");
		pv = 8'($random(seed));
		reg_wr(SWC_A_IOC, pv);
		reg_rd(SWC_A_IOC, pv, "pin change enables");
		reg_wr(SWC_A_PERIPH_ENABLES_TWO, 8'hFF);
		reg_rd(SWC_A_PERIPH_ENABLES_TWO, SWC_PERIPH_ENABLES_TWO_MASK, "periph enables two");
		reg_wr(4'hC, 8'hFF);
		reg_rd(4'hC, 8'h00, "unmapped");
		$display("test registers done");
		reg_wr(SWC_A_ICTL, 8'h00);
		pv = 8'($random(seed));
		pout_core <= pv;
		poe_core <= ~pv;
		core.sleep(1'b1);
		#1;
		check("sleep outputs", {2'b00, core_clk_en, osc_drv_en, wdt_clear, prefetch_next, lp_en,
			ext_n}, 8'h0F);
		@(posedge sys_clk) pout_core <= ~pv;
		poe_core <= pv;
		repeat (3) @(posedge sys_clk);
		check("port_out", port_out, pv);
		check("port_oe", port_oe, ~pv);
		reg_rd(SWC_A_STAT, 8'h11, "status asleep");
		pin_pulse();
		repeat (5) @(posedge sys_clk);
		check("disabled source", {7'h00, core_clk_en}, 8'h00);
		reg_wr(SWC_A_ICTL, 8'h12);
		wait_hi(0, n);
		check("wake clear", {7'h00, wdt_clear}, 8'h01);
		@(posedge sys_clk);
		#1;
		check("no vector", {7'h00, vector_req}, 8'h00);
		$display("test sleep and interrupt wake done");
		core.sleep(1'b1);
		#1;
		check("pending no-op", {7'h00, core_clk_en}, 8'h01);
		reg_rd(SWC_A_STAT, 8'h18, "status no-op");
		$display("test pending interrupt done");
		reg_wr(SWC_A_ICTL, 8'hC0);
		reg_wr(SWC_A_PERIPH_ENABLES_ONE, 8'h01);
		qual.low_power_timer_async <= 1'b1;
		core.sleep(1'b1);
		@(posedge sys_clk) raise <= 8'h01;
		@(posedge sys_clk) raise <= 8'h00;
		wait_hi(0, n);
		@(posedge sys_clk);
		#1;
		check("vector req", {7'h00, vector_req}, 8'h01);
		check("vector addr", vector_addr, SWC_VECTOR);
		$display("test vectored wake done");
		reg_wr(SWC_A_ICTL, 8'h00);
		reg_wr(SWC_A_PERIPH_FLAGS_ONE, 8'h00);
		core.sleep(1'b1);
		core.timeout();
		wait_hi(0, n);
		reg_rd(SWC_A_STAT, 8'h00, "status watchdog wake");
		core.timeout();
		#1;
		check("internal reset", {6'h00, wdt_reset_int, ext_n}, 8'h03);
		$display("test watchdog done");
		wdt_enable <= 1'b0;
		reg_wr(SWC_A_IOC, 8'hFF);
		reg_wr(SWC_A_ICTL, 8'h08);
		core.sleep(1'b0);
		#1;
		check("no watchdog clear", {7'h00, wdt_clear}, 8'h00);
		@(posedge sys_clk) pins <= pins ^ (8'($random(seed)) | 8'h01);
		wait_hi(0, n);
		check("pin change wake", {7'h00, wdt_clear}, 8'h01);
		reg_rd(SWC_A_ICTL, 8'h09, "pin change flag");
		reg_wr(SWC_A_ICTL, 8'h00);
		core.sleep(1'b0);
		@(posedge sys_clk) cap_b <= 1'b1;
		@(posedge sys_clk) cap_b <= 1'b0;
		wait_hi(0, n);
		check("capture b wake", 8'(n), 8'h01);
		reg_rd(SWC_A_PERIPH_FLAGS_TWO, 8'h01, "capture b flag");
		reg_wr(SWC_A_PERIPH_FLAGS_TWO, 8'h00);
		wdt_enable <= 1'b1;
		$display("test pin change and capture wake done");
		reg_wr(SWC_A_CFG, 8'h01);
		reg_wr(SWC_A_ICTL, 8'h10);
		core.sleep(1'b1);
		pin_pulse();
		#1;
		check("crystal wake", {6'h00, wdt_clear, core_clk_en}, 8'h02);
		wait_hi(0, n);
		check("start-up delay", 8'(n), 8'(OST));
		for (int i = 0; i < 4; i++) begin
			qp = {6'h00, q_phase + 2'd1};
			@(posedge sys_clk);
			#1;
			check("q_phase", {6'h00, q_phase}, qp);
		end
		$display("test crystal start-up done");
		reg_wr(SWC_A_ICTL, 8'h00);
		reg_wr(SWC_A_CFG, 8'h00);
		core.sleep(1'b1);
		@(posedge sys_clk) nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		#1;
		check("pin reset wake", {7'h00, core_clk_en}, 8'h01);
		reg_rd(SWC_A_STAT, 8'h18, "status after pin reset");
		repeat (3) @(posedge sys_clk);
		$display("test pin reset done");
		complete_run();
	end
endmodule
`default_nettype wire
